/* File: design/amdp_defines.svh */
// Constants for the multidrop serial host: characters, offsets, positions and resets.
// Assumes inclusion by bare name from the host module, the drive model and the bench.
`ifndef AMDP_DEFINES_SVH
`define AMDP_DEFINES_SVH
// ----------------------------------------
// Control characters
// ----------------------------------------
`define AMDP_CH_STX 8'h02
`define AMDP_CH_ETX 8'h03
`define AMDP_CH_EOT 8'h04
`define AMDP_CH_ENQ 8'h05
`define AMDP_CH_ACK 8'h06
`define AMDP_CH_BS 8'h08
`define AMDP_CH_NAK 8'h15
`define AMDP_DIG_HI 4'h3
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AMDP_OFF_CTRL 8'h00
`define AMDP_OFF_ADDR 8'h04
`define AMDP_OFF_PARAM 8'h08
`define AMDP_OFF_WDLO 8'h0C
`define AMDP_OFF_WDHI 8'h10
`define AMDP_OFF_STAT 8'h14
`define AMDP_OFF_RPARAM 8'h18
`define AMDP_OFF_RDLO 8'h1C
`define AMDP_OFF_RDHI 8'h20
`define AMDP_OFF_BAUD 8'h24
// ----------------------------------------
// Message positions and line timing
// ----------------------------------------
`define AMDP_POS_STX 5'h05
`define AMDP_POS_ENQ 5'h09
`define AMDP_POS_WPAR 5'h06
`define AMDP_POS_WDAT 5'h0A
`define AMDP_RX_DAT 4'h4
`define AMDP_RX_ETX 4'h9
`define AMDP_RX_BCC 4'hA
`define AMDP_MAX_LEN 3'h5
`define AMDP_BIT_MID 4'h7
`define AMDP_BIT_LAST 4'hF
`define AMDP_BIT_STOP 4'h9
`define AMDP_BAUD_RST 16'h065B
`endif

/* File: design/amdp_pkg.sv */
// Types shared by the multidrop serial host.
// Assumes amdp_defines.svh is on the include path.
package amdp_pkg;
   typedef enum logic [1:0] {CMD_RD = 2'b00, CMD_WR = 2'b01, CMD_NEXT = 2'b10,
      CMD_PREV = 2'b11} amdp_cmd_t;
   typedef enum logic [2:0] {RES_NONE = 3'b000, RES_ACK = 3'b001, RES_NAK = 3'b010,
      RES_EOT = 3'b011, RES_REPLY = 3'b100, RES_BAD = 3'b101, RES_TMO = 3'b110,
      RES_BCAST = 3'b111} amdp_res_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01, ST_WAIT = 2'b10,
      ST_RECV = 2'b11} amdp_state_t;
   typedef struct packed {
      amdp_cmd_t cmd;
      logic [7:0] addr;
      logic [15:0] param;
      logic [2:0] len;
      logic [39:0] data;
   } amdp_job_t;
endpackage

/* File: design/amdp_host.sv */
// Host controller for an ASCII multidrop drive link: APB orders in, 8N1 serial out.
// Assumes one 250 MHz clock, an RS422 4-wire line without echo, and an APB master.
//
// Added by the designer: the address map and the APB slave port.
`include "amdp_defines.svh"

module amdp_host
   import amdp_pkg::*;
#(
   parameter int unsigned REPLY_TIMEOUT = 1000000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic txd,
   input wire logic rxd,
   output logic busy
);
   amdp_state_t state_q;
   amdp_res_t res_q;
   amdp_job_t job_q;
   logic [15:0] baud_q, div_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q, rparam_q, tmo_q;
   logic [39:0] rdata_q;
   logic [4:0] idx_q;
   logic [7:0] bcc_q, rbcc_q, rsh_q;
   logic [3:0] rcnt_q, ttk_q, tbit_q, rtk_q, rbit_q;
   logic [9:0] tsh_q;
   logic tx_busy_q, rxd_s1_q, rxd_s2_q, rx_act_q, rx_stb_q;

   // ----------------------------------------
   // Message character builder
   // ----------------------------------------
   function automatic logic [7:0] char_at(amdp_job_t j, logic [4:0] i, logic [7:0] b);
      logic [4:0] k;
      logic [4:0] d;
      k = 5'(i - ((j.cmd == CMD_WR) ? `AMDP_POS_WPAR : `AMDP_POS_STX));
      d = 5'(i - `AMDP_POS_WDAT);
      char_at = b;
      if (j.cmd == CMD_NEXT)
         char_at = `AMDP_CH_ACK;
      else if (j.cmd == CMD_PREV)
         char_at = `AMDP_CH_BS;
      else if (i == 5'h00)
         char_at = `AMDP_CH_EOT;
      else if (i < 5'h03)
         char_at = {`AMDP_DIG_HI, j.addr[7:4]};
      else if (i < `AMDP_POS_STX)
         char_at = {`AMDP_DIG_HI, j.addr[3:0]};
      else if (j.cmd == CMD_WR && i == `AMDP_POS_STX)
         char_at = `AMDP_CH_STX;
      else if (k < 5'h04)
         char_at = {`AMDP_DIG_HI, j.param[5'(15 - 4 * k) -: 4]};
      else if (j.cmd == CMD_RD)
         char_at = `AMDP_CH_ENQ;
      else if (d < 5'(j.len))
         char_at = j.data[8 * d[2:0] +: 8];
      else if (d == 5'(j.len))
         char_at = `AMDP_CH_ETX;
   endfunction

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   wire acc = psel & penable;
   wire wr_en = acc & pready_q & pwrite;
   wire idle = (state_q == ST_IDLE);
   wire wr_ok = wr_en & idle;
   wire start = wr_ok & (paddr == `AMDP_OFF_CTRL) & pwdata[0];
   wire map_ok = (paddr[1:0] == 2'h0) & (paddr <= `AMDP_OFF_BAUD);
   wire [2:0] len_in = (pwdata[10:8] > `AMDP_MAX_LEN) ? `AMDP_MAX_LEN : pwdata[10:8];
   wire [31:0] rd_mux =
      (paddr == `AMDP_OFF_CTRL) ? {29'h0, job_q.cmd, 1'b0} :
      (paddr == `AMDP_OFF_ADDR) ? {24'h0, job_q.addr} :
      (paddr == `AMDP_OFF_PARAM) ? {16'h0, job_q.param} :
      (paddr == `AMDP_OFF_WDLO) ? job_q.data[31:0] :
      (paddr == `AMDP_OFF_WDHI) ? {21'h0, job_q.len, job_q.data[39:32]} :
      (paddr == `AMDP_OFF_STAT) ? {28'h0, res_q, busy} :
      (paddr == `AMDP_OFF_RPARAM) ? rparam_q :
      (paddr == `AMDP_OFF_RDLO) ? rdata_q[31:0] :
      (paddr == `AMDP_OFF_RDHI) ? {24'h0, rdata_q[39:32]} :
      (paddr == `AMDP_OFF_BAUD) ? {16'h0, baud_q} : 32'h0;
   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & pready_q;
   assign busy = ~idle;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         pready_q <= acc & ~pready_q;
         pslverr_q <= ~map_ok;
         if (acc & ~pready_q & ~pwrite)
            prdata_q <= rd_mux;
      end

   // Job fields are frozen while a message is in flight so the checksum stays coherent.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         job_q <= '0;
         baud_q <= `AMDP_BAUD_RST;
      end
      else if (wr_ok)
      begin
         if (paddr == `AMDP_OFF_CTRL)
            job_q.cmd <= amdp_cmd_t'(pwdata[2:1]);
         if (paddr == `AMDP_OFF_ADDR)
            job_q.addr <= pwdata[7:0];
         if (paddr == `AMDP_OFF_PARAM)
            job_q.param <= pwdata[15:0];
         if (paddr == `AMDP_OFF_WDLO)
            job_q.data[31:0] <= pwdata;
         if (paddr == `AMDP_OFF_WDHI)
         begin
            job_q.data[39:32] <= pwdata[7:0];
            job_q.len <= len_in;
         end
         if (paddr == `AMDP_OFF_BAUD)
            baud_q <= pwdata[15:0];
      end

   // ----------------------------------------
   // Baud divider and serial transmitter
   // ----------------------------------------
   // line rate from divisor
   wire tick = (div_q >= baud_q);
   wire bcast = (job_q.addr == 8'h00) & (job_q.cmd != CMD_NEXT) & (job_q.cmd != CMD_PREV);
   wire tx_load = (state_q == ST_SEND) & ~tx_busy_q;
   wire [7:0] tx_char = char_at(job_q, idx_q, bcc_q);
   wire tx_last = (job_q.cmd == CMD_RD) ? (idx_q == `AMDP_POS_ENQ) :
      (job_q.cmd == CMD_WR) ? (idx_q == 5'(`AMDP_POS_WDAT + 5'(job_q.len) + 5'h01)) :
      (idx_q == 5'h00);
   assign txd = tsh_q[0];

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         div_q <= 16'h0;
      else
         div_q <= tick ? 16'h0 : 16'(div_q + 16'h1);

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tsh_q <= 10'h3FF;
         tx_busy_q <= 1'b0;
         ttk_q <= 4'h0;
         tbit_q <= 4'h0;
      end
      else if (tx_load)
      begin
         tsh_q <= {1'b1, tx_char, 1'b0};
         tx_busy_q <= 1'b1;
         ttk_q <= 4'h0;
         tbit_q <= 4'h0;
      end
      else if (tx_busy_q & tick)
      begin
         ttk_q <= 4'(ttk_q + 4'h1);
         if (ttk_q == `AMDP_BIT_LAST)
         begin
            tsh_q <= {1'b1, tsh_q[9:1]};
            tbit_q <= 4'(tbit_q + 4'h1);
            tx_busy_q <= (tbit_q != `AMDP_BIT_STOP);
         end
      end

   // ----------------------------------------
   // Serial receiver
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rxd_s1_q <= 1'b1;
         rxd_s2_q <= 1'b1;
         rx_act_q <= 1'b0;
         rtk_q <= 4'h0;
         rbit_q <= 4'h0;
         rsh_q <= 8'h0;
         rx_stb_q <= 1'b0;
      end
      else
      begin
         rxd_s1_q <= rxd;
         rxd_s2_q <= rxd_s1_q;
         rx_stb_q <= 1'b0;
         if (!rx_act_q & !rxd_s2_q)
         begin
            rx_act_q <= 1'b1;
            rtk_q <= 4'h0;
            rbit_q <= 4'h0;
         end
         else if (rx_act_q & tick)
         begin
            rtk_q <= 4'(rtk_q + 4'h1);
            if (rtk_q == `AMDP_BIT_MID)
            begin
               rbit_q <= 4'(rbit_q + 4'h1);
               if ((rbit_q == 4'h0 && rxd_s2_q) || rbit_q == `AMDP_BIT_STOP)
                  rx_act_q <= 1'b0;
               if (rbit_q == `AMDP_BIT_STOP)
                  rx_stb_q <= rxd_s2_q;
               else if (rbit_q != 4'h0)
                  rsh_q <= {rxd_s2_q, rsh_q[7:1]};
            end
         end
      end

   // ----------------------------------------
   // Message sequencer
   // ----------------------------------------
   wire [2:0] rdi = 3'(rcnt_q - `AMDP_RX_DAT);
   wire tmo_hit = (tmo_q == REPLY_TIMEOUT);

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         res_q <= RES_NONE;
         idx_q <= 5'h00;
         bcc_q <= 8'h00;
         rbcc_q <= 8'h00;
         rcnt_q <= 4'h0;
         tmo_q <= 32'h0;
         rparam_q <= 32'h0;
         rdata_q <= 40'h0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (start)
               begin
                  state_q <= ST_SEND;
                  res_q <= RES_NONE;
                  idx_q <= 5'h00;
                  bcc_q <= 8'h00;
               end
            ST_SEND:
               if (tx_load)
               begin
                  idx_q <= 5'(idx_q + 5'h01);
                  if (job_q.cmd == CMD_WR && idx_q >= `AMDP_POS_WPAR && !tx_last)
                     bcc_q <= bcc_q ^ tx_char;
                  if (tx_last)
                  begin
                     state_q <= ST_WAIT;
                     tmo_q <= 32'h0;
                  end
               end
            ST_WAIT:
               if (bcast & ~tx_busy_q)
               begin
                  state_q <= ST_IDLE;
                  res_q <= RES_BCAST;
               end
               else if (rx_stb_q)
               begin
                  state_q <= (rsh_q == `AMDP_CH_STX) ? ST_RECV : ST_IDLE;
                  rcnt_q <= 4'h0;
                  rbcc_q <= 8'h00;
                  res_q <= (rsh_q == `AMDP_CH_ACK) ? RES_ACK :
                     (rsh_q == `AMDP_CH_NAK) ? RES_NAK :
                     (rsh_q == `AMDP_CH_EOT) ? RES_EOT :
                     (rsh_q == `AMDP_CH_STX) ? RES_NONE : RES_BAD;
               end
               else if (tmo_hit)
               begin
                  state_q <= ST_IDLE;
                  res_q <= RES_TMO;
               end
               else if (~tx_busy_q)
                  tmo_q <= 32'(tmo_q + 32'h1);
            ST_RECV:
               if (rx_stb_q)
               begin
                  rcnt_q <= 4'(rcnt_q + 4'h1);
                  rbcc_q <= rbcc_q ^ rsh_q;
                  if (rcnt_q < `AMDP_RX_DAT)
                     rparam_q[8 * rcnt_q[1:0] +: 8] <= rsh_q;
                  else if (rcnt_q < `AMDP_RX_ETX)
                     rdata_q[8 * rdi +: 8] <= rsh_q;
                  else if (rcnt_q == `AMDP_RX_ETX && rsh_q != `AMDP_CH_ETX)
                  begin
                     state_q <= ST_IDLE;
                     res_q <= RES_BAD;
                  end
                  else if (rcnt_q == `AMDP_RX_BCC)
                  begin
                     state_q <= ST_IDLE;
                     res_q <= (rsh_q == rbcc_q) ? RES_REPLY : RES_BAD;
                  end
               end
               else if (tmo_hit)
               begin
                  state_q <= ST_IDLE;
                  res_q <= RES_TMO;
               end
               else
                  tmo_q <= 32'(tmo_q + 32'h1);
         endcase
      end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_eot_opens: assert property (tx_load && idx_q == 5'h00 && bcast == (job_q.addr == 8'h00)
      && job_q.cmd inside {CMD_RD, CMD_WR} |-> tx_char == `AMDP_CH_EOT)
      else $error("message does not open with reset");
   a_enq_closes: assert property (tx_load && tx_last && job_q.cmd == CMD_RD
      |=> state_q == ST_WAIT ##0 tsh_q[8:1] == `AMDP_CH_ENQ)
      else $error("read does not end with enquiry");
   a_ack_result: assert property (state_q == ST_WAIT && rx_stb_q && !bcast
      && rsh_q == `AMDP_CH_ACK |=> res_q == RES_ACK && state_q == ST_IDLE)
      else $error("positive acknowledge not reported");
   a_bs_step: assert property (tx_load && job_q.cmd == CMD_PREV
      |=> tsh_q[8:1] == `AMDP_CH_BS ##1 state_q == ST_WAIT)
      else $error("previous step does not send backspace");
   a_addr_doubled: assert property (tx_load && job_q.cmd inside {CMD_RD, CMD_WR}
      && idx_q == 5'h03 |-> tx_char == {`AMDP_DIG_HI, job_q.addr[3:0]})
      else $error("second address digit wrong");
   a_param_first: assert property (tx_load && job_q.cmd == CMD_RD && idx_q == `AMDP_POS_STX
      |-> tx_char == {`AMDP_DIG_HI, job_q.param[15:12]})
      else $error("parameter digits misplaced");
   a_bcc_final: assert property (tx_load && tx_last && job_q.cmd == CMD_WR
      |-> tx_char == bcc_q && $past(tx_busy_q))
      else $error("checksum character wrong");
   a_line_idle: assert property (!tx_busy_q && !tx_load |-> txd)
      else $error("line not idle between characters");
   a_start_bit: assert property ($rose(tx_busy_q) |-> !txd ##1 !txd)
      else $error("start bit missing");
   c_read_reply: cover property (state_q == ST_RECV ##1 res_q == RES_REPLY);
   c_write_ack: cover property (job_q.cmd == CMD_WR && res_q == RES_ACK);
   c_bcast: cover property (res_q == RES_BCAST);
   c_timeout: cover property (res_q == RES_TMO);
endmodule

/* File: testbench/amdp_drive_model.sv */
// Behavioural drive on the far side of the serial line: decodes host messages,
// keeps a small parameter store and answers. Assumes 8N1 at BIT clocks a bit.
`include "amdp_defines.svh"
module amdp_drive_model
#(
   parameter int BIT = 16,
   parameter logic [7:0] MY_ADDR = 8'h23,
   parameter int MODE = 1,
   parameter int LOSS = 50000
)
(
   input wire logic clk,
   input wire logic line_in,
   output logic line_out,
   input wire logic corrupt,
   input wire logic slow,
   output logic [7:0] rx_byte,
   output logic rx_stb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] msg[$];
   logic [39:0] mem[logic [15:0]];
   logic [15:0] last;
   logic last_ok = 1'b0;
   int quiet = 0;
   int trip_code = 0;

   // silent line trips
   // A long quiet line records the link-loss trip; stored values are frozen from then on.
   always @(posedge clk)
   begin
      quiet = line_in ? quiet + 1 : 0;
      if (quiet > LOSS && trip_code == 0)
         trip_code = 105;
   end

   task automatic get(output logic [7:0] b);
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge clk);
         b[i] = line_in;
      end
      repeat (BIT) @(posedge clk);
      rx_byte <= b;
      rx_stb <= 1'b1;
      @(posedge clk);
      rx_stb <= 1'b0;
   endtask

   task automatic put(input logic [7:0] b);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         line_out <= b[i];
         repeat (BIT) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask

   // Turnaround lets the host finish its own stop bit before we answer.
   task automatic turn();
      repeat (2 * BIT + (slow ? 1000 : 0)) @(posedge clk);
   endtask

   function automatic logic [15:0] pat(input int k);
      return {msg[k][3:0], msg[k+1][3:0], msg[k+2][3:0], msg[k+3][3:0]};
   endfunction

   function automatic logic [15:0] step(input logic [15:0] p, input int dir);
      int n;
      n = p[15:12] * 1000 + p[11:8] * 100 + p[7:4] * 10 + p[3:0] + dir;
      return {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
   endfunction

   task automatic reply(input logic [15:0] p);
      logic [39:0] v;
      logic [7:0] c;
      logic [7:0] bcc;
      v = mem.exists(p) ? mem[p] : 40'h3030303030;
      bcc = `AMDP_CH_ETX ^ {7'h0, corrupt};
      put(`AMDP_CH_STX);
      for (int i = 0; i < 9; i++)
      begin
         c = i < 4 ? {`AMDP_DIG_HI, p[15-4*i -: 4]} : v[8*(i-4) +: 8];
         bcc ^= c;
         put(c);
      end
      put(`AMDP_CH_ETX);
      put(bcc);
      last = p;
      last_ok = 1'b1;
   endtask

   initial
   begin
      logic [7:0] b;
      logic [7:0] a;
      logic [7:0] s;
      logic [15:0] p;
      logic [39:0] v;
      logic hit;
      logic ok;
      int n;
      line_out = 1'b1;
      rx_stb = 1'b0;
      rx_byte = 8'h00;
      forever
      begin
         get(b);
         if (b == `AMDP_CH_EOT)
            msg.delete();
         else if (msg.size() == 0 && last_ok && (b == `AMDP_CH_ACK || b == `AMDP_CH_BS))
         begin
            turn();
            reply(step(last, b == `AMDP_CH_ACK ? 1 : -1));
         end
         else
         begin
            msg.push_back(b);
            a = {msg[0][3:0], msg.size() > 2 ? msg[2][3:0] : 4'h0};
            hit = msg.size() > 3 && msg[0] == msg[1] && msg[2] == msg[3];
            hit = hit && (a == MY_ADDR || a == 8'h00);
            hit = hit && MODE == 1;
            n = msg.size() - 11;
            if (msg.size() == 9 && b == `AMDP_CH_ENQ)
            begin
               p = pat(4);
               if (hit && a != 8'h00)
               begin
                  turn();
                  if (p[15:12] != 4'h0)
                     put(`AMDP_CH_EOT);
                  else
                     reply(p);
               end
               msg.delete();
            end
            else if (n >= 0 && msg[4] == `AMDP_CH_STX && msg[msg.size()-2] == `AMDP_CH_ETX)
            begin
               s = 8'h00;
               for (int i = 5; i < msg.size() - 1; i++)
                  s ^= msg[i];
               ok = s == msg[msg.size()-1] && n <= 5 && !corrupt;
               v = 40'h3030303030;
               for (int i = 0; i < n && n <= 5; i++)
                  v[8*(5-n+i) +: 8] = msg[9+i];
               if (hit && ok && trip_code == 0)
                  mem[pat(5)] = v;
               if (hit && a != 8'h00)
               begin
                  turn();
                  put(ok ? `AMDP_CH_ACK : `AMDP_CH_NAK);
               end
               msg.delete();
            end
         end
      end
   end
endmodule

/* File: testbench/amdp_host_bench.sv */
// Self-checking bench for the multidrop host: APB orders in, drive model on the line.
// Assumes the host answers APB in two access cycles and runs with BAUD set to 0.
`include "amdp_defines.svh"
module amdp_host_bench;
   import amdp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic txd;
   logic rxd;
   logic busy;
   logic corrupt = 1'b0;
   logic slow = 1'b0;
   logic [7:0] tx_byte;
   logic tx_stb;
   logic [31:0] q;
   logic [39:0] rv;
   logic [32:0] exp_q[$];
   logic [7:0] tx_q[$];
   int err_count = 0;
   int tests_run = 0;

   always #2 pclk = ~pclk;

   amdp_host #(.REPLY_TIMEOUT(4000)) i_amdp_host (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd), .busy(busy));
   // one drive, line rate matched to BAUD 0
   amdp_drive_model #(.BIT(16), .MY_ADDR(8'h23)) i_amdp_drive_model (.clk(pclk),
      .line_in(txd), .line_out(rxd), .corrupt(corrupt), .slow(slow), .rx_byte(tx_byte),
      .rx_stb(tx_stb));

   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Monitors
   // ----------------------------------------
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         chk("apb read", {pslverr, prdata}, exp_q.pop_front());
      if (tx_stb)
         chk("tx char", {25'h0, tx_byte}, tx_q.size() > 0 ? {25'h0, tx_q.pop_front()} : 33'h100);
   end

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         err_count++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   function automatic logic [31:0] pc(input logic [15:0] p);
      return {4'h3, p[3:0], 4'h3, p[7:4], 4'h3, p[11:8], 4'h3, p[15:12]};
   endfunction

   // One order: notes the expected line characters, starts it, waits, checks the result.
   task automatic order(input amdp_cmd_t c, input logic [7:0] a, input logic [15:0] p,
      input logic [2:0] n, input logic [39:0] d, input amdp_res_t res);
      logic [7:0] bcc;
      int k;
      bcc = `AMDP_CH_ETX;
      if (c == CMD_NEXT || c == CMD_PREV)
         tx_q.push_back(c == CMD_NEXT ? `AMDP_CH_ACK : `AMDP_CH_BS);
      else
      begin
         tx_q.push_back(`AMDP_CH_EOT);
         for (int i = 0; i < 4; i++)
            tx_q.push_back({`AMDP_DIG_HI, i < 2 ? a[7:4] : a[3:0]});
         if (c == CMD_WR)
            tx_q.push_back(`AMDP_CH_STX);
         for (int i = 0; i < 4 + (c == CMD_WR ? n : 0); i++)
         begin
            tx_q.push_back(i < 4 ? {`AMDP_DIG_HI, p[15-4*i -: 4]} : d[8*(i-4) +: 8]);
            bcc ^= tx_q[tx_q.size()-1];
         end
         tx_q.push_back(c == CMD_WR ? `AMDP_CH_ETX : `AMDP_CH_ENQ);
         if (c == CMD_WR)
            tx_q.push_back(bcc);
      end
      apb(1'b1, `AMDP_OFF_ADDR, {24'h0, a});
      apb(1'b1, `AMDP_OFF_PARAM, {16'h0, p});
      apb(1'b1, `AMDP_OFF_WDLO, d[31:0]);
      apb(1'b1, `AMDP_OFF_WDHI, {21'h0, n, d[39:32]});
      apb(1'b1, `AMDP_OFF_CTRL, {29'h0, c, 1'b1});
      chk("busy pin", {32'h0, busy}, 33'h1);
      apb(1'b1, `AMDP_OFF_ADDR, 32'h99);
      k = 0;
      do
      begin
         apb(1'b0, `AMDP_OFF_STAT, 32'h0);
         k++;
      end
      while (q[0] !== 1'b0 && k < 3000);
      if (k >= 3000)
      begin
         err_count++;
         report_and_stop();
      end
      chk("busy pin", {32'h0, busy}, 33'h0);
      rd(`AMDP_OFF_STAT, {29'h0, res, 1'b0});
      rd(`AMDP_OFF_ADDR, {25'h0, a});
   endtask

   task automatic got(input logic [15:0] p, input logic [39:0] v);
      rd(`AMDP_OFF_RPARAM, pc(p));
      rd(`AMDP_OFF_RDLO, v[31:0]);
      rd(`AMDP_OFF_RDHI, {24'h0, v[39:32]});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'hB551));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`AMDP_OFF_BAUD, {17'h0, `AMDP_BAUD_RST});
      rd(`AMDP_OFF_STAT, 33'h0);
      rd(8'h28, 33'h1_0000_0000);
      rd(8'h02, 33'h1_0000_0000);
      apb(1'b1, `AMDP_OFF_BAUD, 32'h0);
      for (int i = 0; i < 5; i++)
         rv[8*i +: 8] = {4'h3, 4'($urandom % 10)};
      order(CMD_WR, 8'h23, 16'h0426, 3'h5, rv, RES_ACK);
      order(CMD_RD, 8'h23, 16'h0426, 3'h0, 40'h0, RES_REPLY);
      got(16'h0426, rv);
      order(CMD_WR, 8'h23, 16'h0427, 3'h1, 40'h31, RES_ACK);
      order(CMD_NEXT, 8'h23, 16'h0, 3'h0, 40'h0, RES_REPLY);
      got(16'h0427, 40'h3130303030);
      order(CMD_PREV, 8'h23, 16'h0, 3'h0, 40'h0, RES_REPLY);
      got(16'h0426, rv);
      order(CMD_RD, 8'h23, 16'h1723, 3'h0, 40'h0, RES_EOT);
      order(CMD_RD, 8'h45, 16'h0426, 3'h0, 40'h0, RES_TMO);
      order(CMD_WR, 8'h00, 16'h0101, 3'h2, 40'h3231, RES_BCAST);
      order(CMD_RD, 8'h23, 16'h0101, 3'h0, 40'h0, RES_REPLY);
      got(16'h0101, 40'h3231303030);
      corrupt <= 1'b1;
      order(CMD_RD, 8'h23, 16'h0426, 3'h0, 40'h0, RES_BAD);
      order(CMD_WR, 8'h23, 16'h0426, 3'h0, 40'h0, RES_NAK);
      corrupt <= 1'b0;
      slow <= 1'b1;
      order(CMD_RD, 8'h23, 16'h0426, 3'h0, 40'h0, RES_REPLY);
      got(16'h0426, rv);
      slow <= 1'b0;
      chk("tx left", 33'(tx_q.size()), 33'h0);
      report_and_stop();
   end
endmodule
